// *** dim_far_side.sv ***
`timescale 1ns/1ps
// contacts, serial master and operator keys facing the drive
module dim_far_side (
    input wire logic [4:0] i_want,
    output logic o_din1,
    output logic o_din2,
    output logic o_din3,
    output logic o_serial_run,
    output logic o_stop_key
);
    // contacts follow the scenario; stop key pressed only when asked
    always_comb
    begin
        {o_din1, o_din2, o_din3, o_serial_run} = i_want[4:1];
        o_stop_key = i_want[0];
    end
endmodule : dim_far_side

// *** dim_input_mapper_fault_log.sv ***
`timescale 1ns/1ps
module dim_input_mapper_fault_log #(
    parameter int AIN_W = 10,
    parameter int TRACE_W = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_ctrl_source,
    input wire logic [3:0] i_input_func,
    input wire logic i_din1,
    input wire logic i_din2,
    input wire logic i_din3,
    input wire logic [AIN_W-1:0] i_ain1,
    input wire logic [AIN_W-1:0] i_ain2,
    input wire logic i_serial_run,
    input wire logic i_keypad_autostart,
    input wire logic [1:0] i_restart_mode_select,
    input wire logic i_fault_evt,
    input wire logic [7:0] i_fault_code,
    input wire logic i_fault_cause,
    input wire logic i_stop_key,
    input wire logic i_reenable,
    input wire logic i_dir_rev,
    input wire logic i_jog,
    input wire logic [TRACE_W-1:0] i_trace,
    output logic o_motor_en,
    output logic [2:0] o_ref_sel,
    output logic o_fb_from_ain1,
    output logic [AIN_W-1:0] o_feedback,
    output logic o_fault,
    output logic [7:0] o_display_code,
    output logic o_led_stop,
    output logic o_led_fwd,
    output logic o_led_rev,
    output logic o_led_jog,
    output logic o_ready,
    output logic o_restart_pulse,
    output dim_pkg::dim_log_entry_t o_recent_fault_log [dim_pkg::LOG_DEPTH],
    output logic [TRACE_W-1:0] o_trace_log [dim_pkg::LOG_DEPTH]
);

    // band width in counts of full scale
    localparam logic [AIN_W-1:0] HYST_CNT =
        AIN_W'((((1 << AIN_W) - 1) * dim_pkg::HYST_PCT) / 100);

    // a beats b by more than the band; spare bit keeps the sum from wrapping
    function automatic logic beats_by_band(input logic [AIN_W-1:0] a,
        input logic [AIN_W-1:0] b);
        return {1'b0, a} > ({1'b0, b} + {1'b0, HYST_CNT});
    endfunction : beats_by_band

    // function selects the trip-enabled group (3,6,7)
    function automatic logic is_trip_fn(input logic [3:0] fn);
        return fn == dim_pkg::FN_TRIP_PRESET || fn == dim_pkg::FN_TRIP_AIN ||
            fn == dim_pkg::FN_TRIP_KEYPAD;
    endfunction : is_trip_fn

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } dim_state_t;

    dim_pkg::dim_decode_t dec;
    dim_state_t state_q, state_d;
    logic fault_q, fault_d;
    logic [7:0] disp_q, disp_d;
    logic restart_q, restart_d;
    logic hold_q, hold_d;
    logic fb_sel_q, fb_sel_d;
    logic [AIN_W-1:0] fb_q, fb_d;
    logic [31:0] time_q, time_d;
    dim_pkg::dim_log_entry_t log_q [dim_pkg::LOG_DEPTH];
    dim_pkg::dim_log_entry_t log_d [dim_pkg::LOG_DEPTH];
    logic [TRACE_W-1:0] trc_q [dim_pkg::LOG_DEPTH];
    logic [TRACE_W-1:0] trc_d [dim_pkg::LOG_DEPTH];
    logic ext_trip, fault_in, run_req, is_ser, is_pi;
    logic [7:0] code_in;

    // terminal decoder, purely combinational from the selectors, inputs 1 and 2, serial run and keypad autostart
    always_comb
    begin
        is_ser = i_ctrl_source == dim_pkg::SRC_SER_A ||
            i_ctrl_source == dim_pkg::SRC_SER_B;
        is_pi = i_ctrl_source == dim_pkg::SRC_PI_A ||
            i_ctrl_source == dim_pkg::SRC_PI_B;
        dec = '0;
        if (is_ser)
        begin
            dec.run_en = i_din1 && i_serial_run;
            dec.ref_sel = dim_pkg::REF_MASTER;
            if (is_trip_fn(i_input_func))
            begin
                dec.ext_trip_en = 1'b1;
                if (i_din2)
                begin
                    if (i_input_func == dim_pkg::FN_TRIP_PRESET)
                        dec.ref_sel = dim_pkg::REF_PRESET1;
                    else if (i_input_func == dim_pkg::FN_TRIP_AIN)
                        dec.ref_sel = dim_pkg::REF_AIN1;
                    else
                        dec.ref_sel = dim_pkg::REF_KEYPAD;
                end
            end
            dec.serial_cmds = dec.ref_sel == dim_pkg::REF_MASTER;
            if (dec.ref_sel == dim_pkg::REF_KEYPAD)
            begin
                dec.auto_start = i_keypad_autostart;
                dec.run_en = i_din1 && i_keypad_autostart;
            end
        end
        else if (is_pi)
        begin
            dec.run_en = i_din1;
            if (!i_din2)
                dec.ref_sel = dim_pkg::REF_PI;
            else if (i_input_func == dim_pkg::FN_ANALOG)
                dec.ref_sel = dim_pkg::REF_AIN1;
            else
                dec.ref_sel = dim_pkg::REF_PRESET1;
            dec.ext_trip_en = is_trip_fn(i_input_func);
            dec.fb_from_ain1 = is_trip_fn(i_input_func);
        end
    end

    // trip only from input 3 and only when assigned
    assign ext_trip = dec.ext_trip_en && !i_din3;
    assign fault_in = i_fault_evt || ext_trip;
    assign code_in = i_fault_evt ? i_fault_code : dim_pkg::FAULT_EXT_TRIP;
    assign run_req = dec.run_en;

    // feedback pick: ain1 for PI trip functions, else ain2; max of the two with hysteresis only for the PI max function
    always_comb
    begin
        fb_sel_d = dec.fb_from_ain1;
        if (is_pi && i_input_func == dim_pkg::FN_MAX_FB)
        begin
            fb_sel_d = fb_sel_q;
            if (!fb_sel_q && beats_by_band(i_ain1, i_ain2))
                fb_sel_d = 1'b1;
            else if (fb_sel_q && beats_by_band(i_ain2, i_ain1))
                fb_sel_d = 1'b0;
        end
        fb_d = fb_sel_d ? i_ain1 : i_ain2;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fb_sel_q <= 1'b0;
            fb_q <= '0;
        end
        else
        begin
            fb_sel_q <= fb_sel_d;
            fb_q <= fb_d;
        end
    end

    // fault state machine and recent-fault log
    always_comb
    begin
        state_d = state_q;
        fault_d = fault_q;
        disp_d = disp_q;
        restart_d = 1'b0;
        time_d = time_q + 32'h1;
        log_d = log_q;
        trc_d = trc_q;
        // a held stop lasts until the run request drops
        hold_d = hold_q && run_req;
        case (state_q)
            ST_IDLE:
                if (run_req && !hold_q)
                    state_d = ST_RUN;
            ST_RUN:
                if (!run_req)
                    state_d = ST_IDLE;
            ST_FAULT:
                // clear refused while cause persists
                if ((i_stop_key || i_reenable) && !i_fault_cause &&
                    !fault_in)
                begin
                    fault_d = 1'b0;
                    disp_d = 8'h00;
                    // mode 0: stay stopped; others restart if asked
                    if (i_restart_mode_select != 2'h0 && run_req)
                    begin
                        state_d = ST_RUN;
                        restart_d = 1'b1;
                    end
                    else
                    begin
                        state_d = ST_IDLE;
                        hold_d = i_restart_mode_select == 2'h0;
                    end
                end
            default:
                state_d = ST_IDLE;
        endcase
        // new fault wins over a start or stop in the same cycle
        if (fault_in && !fault_q)
        begin
            state_d = ST_FAULT;
            fault_d = 1'b1;
            disp_d = code_in;
            restart_d = 1'b0;
            log_d[0].code = code_in;
            log_d[0].stamp = time_q;
            trc_d[0] = i_trace;
            for (int i = 1; i < dim_pkg::LOG_DEPTH; i++)
            begin
                log_d[i] = log_q[i-1];
                trc_d[i] = trc_q[i-1];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= ST_IDLE;
            fault_q <= 1'b0;
            disp_q <= 8'h00;
            restart_q <= 1'b0;
            hold_q <= 1'b0;
            time_q <= dim_pkg::TIME_RESET;
            for (int i = 0; i < dim_pkg::LOG_DEPTH; i++)
            begin
                log_q[i] <= '0;
                trc_q[i] <= '0;
            end
        end
        else
        begin
            state_q <= state_d;
            fault_q <= fault_d;
            disp_q <= disp_d;
            restart_q <= restart_d;
            hold_q <= hold_d;
            time_q <= time_d;
            log_q <= log_d;
            trc_q <= trc_d;
        end
    end

    // outputs: power only while running, coast on fault
    assign o_motor_en = state_q == ST_RUN;
    assign o_ref_sel = dec.ref_sel;
    assign o_fb_from_ain1 = fb_sel_q;
    assign o_feedback = fb_q;
    assign o_fault = fault_q;
    assign o_display_code = disp_q;
    assign o_led_stop = state_q != ST_RUN;
    assign o_led_fwd = state_q == ST_RUN && !i_dir_rev && !i_jog;
    assign o_led_rev = state_q == ST_RUN && i_dir_rev && !i_jog;
    assign o_led_jog = state_q == ST_RUN && i_jog;
    assign o_ready = state_q == ST_IDLE;
    assign o_restart_pulse = restart_q;
    assign o_recent_fault_log = log_q;
    assign o_trace_log = trc_q;

    chk_fault_cuts_power: assert property (@(posedge i_clk)
        disable iff (!i_resetn) (fault_in && !fault_q) |=> !o_motor_en)
        else $error("motor power not removed on fault");
    chk_no_clear_cause: assert property (@(posedge i_clk)
        disable iff (!i_resetn) (fault_q && i_fault_cause) |=> fault_q)
        else $error("fault cleared while cause present");
    chk_log_newest: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (fault_in && !fault_q) |=> log_q[0].code == $past(code_in)
        && log_q[1] == $past(log_q[0]))
        else $error("recent fault log not shifted");
    chk_display_code: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (fault_in && !fault_q) |=> o_display_code == $past(code_in))
        else $error("fault code not displayed");
    chk_trip_din3: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (!is_trip_fn(i_input_func) && !i_fault_evt && !fault_q)
        |=> !fault_q)
        else $error("trip raised without assigned input");
    chk_serial_din1: assert property (@(posedge i_clk)
        disable iff (!i_resetn) (is_ser && !i_din1) |-> !dec.run_en)
        else $error("serial run without input 1");
    chk_pi_feedback: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (is_pi && i_input_func == 4'h0) |=> o_feedback == $past(i_ain2))
        else $error("PI feedback not from analog 2");
    chk_idle_stop: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (!fault_q && !o_motor_en) |-> o_led_stop && !o_led_fwd && o_ready)
        else $error("idle indication wrong");
    chk_hold_stopped: assert property (@(posedge i_clk)
        disable iff (!i_resetn) (hold_q && state_q == ST_IDLE) |=> !o_motor_en)
        else $error("restarted although restart mode holds stop");
endmodule : dim_input_mapper_fault_log

// *** dim_input_mapper_fault_log_tb.sv ***
`timescale 1ns/1ps
module dim_input_mapper_fault_log_tb;
    logic clk = 0, rstn = 0, d1 = 0, d2 = 0, d3 = 1, srun = 0, stopk = 0;
    logic [2:0] src = 3'h0;
    logic [3:0] fn = 4'h0;
    logic [9:0] ain1 = 10'h0, ain2 = 10'h0;
    logic kauto = 0, fevt = 0, cause = 0, reen = 0, rev = 0, jog = 0;
    logic [7:0] c2;
    logic [1:0] rmode = 2'h0;
    logic [7:0] fcode = 8'h0, e;
    logic [15:0] trace = 16'h0;
    logic w1, w2, w3, wrun, wstop, mot, fbs, flt, ls, lf, lr, lj, rdy, rp;
    logic [2:0] rsel;
    logic [9:0] fb;
    logic [7:0] disp;
    dim_pkg::dim_log_entry_t lg [dim_pkg::LOG_DEPTH];
    logic [15:0] tl [dim_pkg::LOG_DEPTH];
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'hB1FA;
    logic [10:0] tbl [9] = '{{3'h3, 4'h3, 1'h0, 3'h1}, {3'h3, 4'h3, 1'h1, 3'h2},
        {3'h3, 4'h6, 1'h1, 3'h3}, {3'h3, 4'h7, 1'h1, 3'h4},
        {3'h3, 4'h7, 1'h0, 3'h1}, {3'h5, 4'h0, 1'h0, 3'h5},
        {3'h5, 4'h0, 1'h1, 3'h2}, {3'h5, 4'h4, 1'h1, 3'h3},
        {3'h6, 4'h3, 1'h1, 3'h2}};
    int n_errors = 0, check_count = 0;
    always #2 clk = ~clk;
    dim_far_side far (.i_want({d1, d2, d3, srun, stopk}), .o_din1(w1),
        .o_din2(w2), .o_din3(w3), .o_serial_run(wrun), .o_stop_key(wstop));
    dim_input_mapper_fault_log DUT (.i_clk(clk), .i_resetn(rstn),
        .i_ctrl_source(src), .i_input_func(fn), .i_din1(w1), .i_din2(w2),
        .i_din3(w3), .i_ain1(ain1), .i_ain2(ain2), .i_serial_run(wrun),
        .i_keypad_autostart(kauto), .i_restart_mode_select(rmode),
        .i_fault_evt(fevt), .i_fault_code(fcode), .i_fault_cause(cause),
        .i_stop_key(wstop), .i_reenable(reen), .i_dir_rev(rev),
        .i_jog(jog), .i_trace(trace), .o_motor_en(mot), .o_ref_sel(rsel),
        .o_fb_from_ain1(fbs), .o_feedback(fb), .o_fault(flt),
        .o_display_code(disp), .o_led_stop(ls), .o_led_fwd(lf),
        .o_led_rev(lr), .o_led_jog(lj), .o_ready(rdy),
        .o_restart_pulse(rp), .o_recent_fault_log(lg), .o_trace_log(tl));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] expv);
        check_count++;
        if (seen !== expv)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, expv, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // one fault, a refused clear, then an accepted one
    task automatic fault(input logic ext, input logic [7:0] c,
        input logic rs);
        seed = lfsr(seed);
        trace = seed[15:0];
        fcode = c;
        exp_q.push_back(ext ? dim_pkg::FAULT_EXT_TRIP : c);
        if (ext) d3 = 0;
        else {fevt, cause} = 2'h3;
        step(1);
        fevt = 0;
        check("motor", mot, 1'b0);
        check("trace", tl[0], trace);
        if (ext) reen = 1;
        else stopk = 1;
        step(2);
        check("held", flt, 1'b1);
        {cause, d3} = 2'h1;
        step(1);
        check("clear", flt, 1'b0);
        check("disp0", disp, 8'h0);
        check("restart", rp, rs);
        {stopk, reen} = 2'h0;
        step(1);
        check("pulse", rp, 1'b0);
        check("rerun", mot, rs);
    endtask : fault
    // result watcher: each new fault is matched against the oldest note
    always @(posedge flt)
    begin
        #1;
        e = exp_q.size() ? exp_q.pop_front() : 8'hFF;
        check("disp", disp, e);
        check("log0", lg[0].code, e);
    end
    // hang guard
    initial
    begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        step(3);
        check("ready", {rdy, ls, mot, flt}, 4'hC);
        rstn = 1;
        step(1);
        foreach (tbl[i])
        begin
            {src, fn, d2} = tbl[i][10:3];
            step(1);
            check("ref", rsel, tbl[i][2:0]);
        end
        {src, fn, d1, d2, srun} = {3'h3, 4'h0, 3'h7};
        step(1);
        check("run", {mot, lf, ls}, 3'h6);
        rev = 1;
        step(1);
        check("rev", lr, 1'b1);
        jog = 1;
        step(1);
        check("jog", {lj, lr, lf}, 3'h4);
        {d1, rev, jog} = 3'h0;
        step(1);
        check("din1", mot, 1'b0);
        {d1, srun} = 2'h2;
        step(1);
        check("serial", mot, 1'b0);
        {fn, d2, srun} = {4'h3, 2'h1};
        step(1);
        check("master", mot, 1'b1);
        {fn, d2, srun, kauto} = {4'h7, 3'h5};
        step(1);
        check("keypad", mot, 1'b1);
        {fn, d2, d3, srun} = {4'h0, 3'h1};
        step(2);
        check("nontrip", flt, 1'b0);
        fn = 4'h3;
        fault(1, 8'h00, 0);
        fn = 4'h0;
        seed = lfsr(seed);
        c2 = seed[7:0] | 8'h02;
        fault(0, c2, 0);
        rmode = 2'h1;
        fault(0, 8'hA5, 1);
        check("log1", lg[1].code, c2);
        check("log2", lg[2].code, dim_pkg::FAULT_EXT_TRIP);
        check("stamp", lg[0].stamp > lg[1].stamp, 1'b1);
        {src, fn, d1, srun} = {3'h5, 4'h0, 2'h0};
        seed = lfsr(seed);
        {ain1, ain2} = seed[19:0];
        step(2);
        check("fb2", {fbs, fb}, {1'b0, ain2});
        fn = 4'h3;
        step(2);
        check("fb1", {fbs, fb}, {1'b1, ain1});
        {fn, ain1, ain2} = {4'h9, 10'd600, 10'd100};
        step(2);
        check("max1", fb, 10'd600);
        ain2 = 10'd630;
        step(2);
        check("band", fb, 10'd600);
        ain2 = 10'd700;
        step(2);
        check("max2", fb, 10'd700);
        {ain1, ain2} = {10'd1000, 10'd990};
        step(2);
        check("top", fb, 10'd990);
        check("queue", exp_q.size(), 32'h0);
        finish_test();
    end
endmodule : dim_input_mapper_fault_log_tb

// *** dim_pkg.sv ***
package dim_pkg;
    // control source selector codes
    localparam logic [2:0] SRC_SER_A = 3'h3;
    localparam logic [2:0] SRC_SER_B = 3'h4;
    localparam logic [2:0] SRC_PI_A = 3'h5;
    localparam logic [2:0] SRC_PI_B = 3'h6;
    // input function selector codes
    localparam logic [3:0] FN_TRIP_PRESET = 4'h3;
    localparam logic [3:0] FN_ANALOG = 4'h4;
    localparam logic [3:0] FN_TRIP_AIN = 4'h6;
    localparam logic [3:0] FN_TRIP_KEYPAD = 4'h7;
    localparam logic [3:0] FN_MAX_FB = 4'h9;
    // speed reference source codes
    localparam logic [2:0] REF_NONE = 3'h0;
    localparam logic [2:0] REF_MASTER = 3'h1;
    localparam logic [2:0] REF_PRESET1 = 3'h2;
    localparam logic [2:0] REF_AIN1 = 3'h3;
    localparam logic [2:0] REF_KEYPAD = 3'h4;
    localparam logic [2:0] REF_PI = 3'h5;
    // fault code of an external trip
    localparam logic [7:0] FAULT_EXT_TRIP = 8'h01;
    // hysteresis band, percent of full scale
    localparam int HYST_PCT = 5;
    localparam int LOG_DEPTH = 4;
    localparam logic [31:0] TIME_RESET = 32'h0;

    typedef struct packed {
        logic run_en;
        logic [2:0] ref_sel;
        logic ext_trip_en;
        logic fb_from_ain1;
        logic serial_cmds;
        logic auto_start;
    } dim_decode_t;

    typedef struct packed {
        logic [7:0] code;
        logic [31:0] stamp;
    } dim_log_entry_t;
endpackage : dim_pkg
